// ### shared/clkgen_pkg.sv
// clkgen_pkg: offsets, field positions, reset values and divider codes
// for the clock prescaler control block.
// assumes an 8-bit cpu data path and 16-bit memory-mapped addresses.
package clkgen_pkg;
  // register byte addresses in the cpu data space
  localparam logic [15:0] SLOW_OSC_MODE_ADDR = 16'hff58;
  localparam logic [15:0] PERIPH_DIV_ADDR = 16'hfff3;
  localparam logic [15:0] CPU_DIV_ADDR = 16'hfffb;
  // reset values
  localparam logic [7:0] SLOW_OSC_MODE_RST = 8'h00;
  localparam logic [7:0] PERIPH_DIV_RST = 8'h02;
  localparam logic [7:0] CPU_DIV_RST = 8'h02;
  // field positions
  localparam int SLOW_OSC_HALT_BIT = 0;
  localparam int CPU_DIVIDE_SELECT_BIT = 1;
  localparam int PERIPH_DIVIDE_LOW_BIT = 0;
  localparam int PERIPH_DIVIDE_HIGH_BIT = 1;
  // writable bits per register, the rest read zero
  localparam logic [7:0] SLOW_OSC_MODE_MASK = 8'h01;
  localparam logic [7:0] PERIPH_DIV_MASK = 8'h03;
  localparam logic [7:0] CPU_DIV_MASK = 8'h02;
  // cpu divide exponent (system clock / 2^n) from {pre1,pre0,proc}
  localparam logic [2:0] CPU_SEL_DIV1 = 3'h0;
  localparam logic [2:0] CPU_SEL_DIV2 = 3'h2;
  localparam logic [2:0] CPU_SEL_DIV4_A = 3'h1;
  localparam logic [2:0] CPU_SEL_DIV4_B = 3'h4;
  localparam logic [2:0] CPU_SEL_DIV8 = 3'h3;
  localparam logic [2:0] CPU_SEL_DIV16 = 3'h5;
  // periph divide codes {pre1,pre0}
  localparam logic [1:0] PER_SEL_DIV1 = 2'h0;
  localparam logic [1:0] PER_SEL_DIV2 = 2'h1;
  localparam logic [1:0] PER_SEL_DIV4 = 2'h2;
  // shortest instruction length in cpu clocks
  localparam int MIN_INSTR_CPU_CLOCKS = 2;
  localparam int PRESCALE_BITS = 4;
endpackage : clkgen_pkg

// ### hdl/clock_prescaler_control.sv
// clock_prescaler_control: system clock selection, two-stage prescaler,
// slow oscillator control and the three cpu-visible control registers.
// assumes the oscillators and the external clock are far slower than
// mclk, so each source level is oversampled; option levels are stable
// while reset is held.
`timescale 1ns/1ps

module clock_prescaler_control (
  input wire logic mclk, // 100 mhz block clock
  input wire logic reset, // synchronous, active high
  input wire logic ce, // clock enable, freezes all state when low unless reset is high
  input wire logic opt_ext_clock, // option: 1 = external clock source
  input wire logic opt_slow_stoppable, // option: software may stop slow osc
  input wire logic hs_osc_clk, // internal high-speed oscillator level
  input wire logic external_clock_pin, // external clock pin level
  input wire logic standby, // cpu in standby
  input wire logic [15:0] addr, // cpu byte address
  input wire logic wr_en, // byte write strobe
  input wire logic bit_wr_en, // single-bit write strobe
  input wire logic [2:0] bit_sel, // bit number for bit write
  input wire logic bit_val, // value for bit write
  input wire logic [7:0] wdata, // byte write data
  input wire logic rd_en, // read strobe
  output logic [7:0] rdata, // read data, one cycle after rd_en
  output logic rd_hit, // read addressed one of our registers
  output logic sys_clk_external, // external source selected
  output logic external_pin_free, // pin released to port logic
  output logic periph_clk, // divided peripheral clock level
  output logic periph_tick, // one-cycle pulse per periph rising edge
  output logic cpu_clk, // divided cpu clock level
  output logic cpu_tick, // one-cycle pulse per cpu rising edge
  output logic [5:0] min_instr_sysclks, // shortest instr in system clocks
  output logic slow_osc_run, // slow oscillator enable
  output logic wdt_slow_forced, // watchdog source pinned to slow clock
  output logic wdt_slow_clk_en, // slow clock delivered to watchdog
  output logic timer_slow_clk_en // slow clock delivered to interval timer
);
  import clkgen_pkg::*;

  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic ext_filt;
    logic sys_lvl;
    logic [PRESCALE_BITS-1:0] cnt;
    logic cpu_sel;
    logic [1:0] per_sel;
    logic slow_halt;
    logic [2:0] cpu_shift;
    logic [1:0] per_shift;
    logic [2:0] pend_cpu_shift;
    logic [1:0] pend_per_shift;
    logic opt_ext;
    logic opt_stop;
    logic [7:0] rdata;
    logic rd_hit;
    logic periph_clk;
    logic cpu_clk;
    logic periph_tick;
    logic cpu_tick;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // cpu exponent for a {pre1,pre0,proc} code; valid flags legal codes
  function automatic logic [3:0] cpu_code(input logic [2:0] c);
    logic [3:0] r;
    r = 4'h0;
    case (c)
      CPU_SEL_DIV1: r = {1'b1, 3'h0};
      CPU_SEL_DIV2: r = {1'b1, 3'h1};
      CPU_SEL_DIV4_A: r = {1'b1, 3'h2};
      CPU_SEL_DIV4_B: r = {1'b1, 3'h2};
      CPU_SEL_DIV8: r = {1'b1, 3'h3};
      CPU_SEL_DIV16: r = {1'b1, 3'h4};
      default: r = 4'h0;
    endcase
    return r;
  endfunction : cpu_code

  // level of the counter tap that a divide exponent selects; inverted so
  // the divided clock rises where its tick fires, at the low bits' wrap
  function automatic logic tap(input logic [PRESCALE_BITS-1:0] c,
                               input logic [2:0] s, input logic lvl);
    logic r;
    r = lvl;
    if (s != 3'h0) begin
      r = ~c[s[1:0] - 2'h1];
    end
    return r;
  endfunction : tap

  // mask of counter bits that must be zero at a divided rising edge
  function automatic logic [PRESCALE_BITS-1:0] edge_mask(
      input logic [2:0] s);
    logic [PRESCALE_BITS-1:0] r;
    r = 4'h0;
    case (s)
      3'h0: r = 4'h0;
      3'h1: r = 4'h1;
      3'h2: r = 4'h3;
      3'h3: r = 4'h7;
      default: r = 4'hf;
    endcase
    return r;
  endfunction : edge_mask

  always_comb begin
    logic sys_src;
    logic sys_rise;
    logic [PRESCALE_BITS-1:0] cnt_n;
    logic [7:0] cpu_v;
    logic [7:0] per_v;
    logic [7:0] slow_v;
    logic [7:0] mask_b;
    logic [3:0] code;
    logic hit_c;
    logic hit_p;
    logic hit_s;
    logic wr_any;
    sys_src = 1'b0;
    sys_rise = 1'b0;
    cnt_n = 4'h0;
    mask_b = 8'h00;
    code = 4'h0;
    cpu_v = 8'h00;
    per_v = 8'h00;
    slow_v = 8'h00;
    hit_c = 1'b0;
    hit_p = 1'b0;
    hit_s = 1'b0;
    wr_any = 1'b0;
    st_next = st_reg;
    st_next.periph_tick = 1'b0;
    st_next.cpu_tick = 1'b0;

    // external pin: three flops, a change counts once s2 and s3 agree
    st_next.ext_s1 = external_clock_pin;
    st_next.ext_s2 = st_reg.ext_s1;
    st_next.ext_s3 = st_reg.ext_s2;
    if (st_reg.ext_s2 == st_reg.ext_s3) begin
      st_next.ext_filt = st_reg.ext_s3;
    end

    // source is fixed by the option latched at reset, never by software
    sys_src = st_reg.opt_ext ? st_reg.ext_filt : hs_osc_clk;
    st_next.sys_lvl = sys_src;
    sys_rise = sys_src & ~st_reg.sys_lvl;

    // one counter feeds both stages so the cpu clock is a strict
    // subdivision of the peripheral clock
    cnt_n = st_reg.cnt;
    if (sys_rise) begin
      cnt_n = st_reg.cnt + 4'h1;
      st_next.cnt = cnt_n;
      // only swap ratios when every tap wraps together, so no stretch
      // or runt period can appear on either divided clock
      if (cnt_n == 4'h0) begin
        st_next.cpu_shift = st_reg.pend_cpu_shift;
        st_next.per_shift = st_reg.pend_per_shift;
      end
      st_next.periph_tick =
        ((cnt_n & edge_mask({1'b0, st_reg.per_shift})) == 4'h0);
      st_next.cpu_tick = ((cnt_n & edge_mask(st_reg.cpu_shift)) == 4'h0);
    end
    st_next.periph_clk = tap(cnt_n, {1'b0, st_reg.per_shift}, sys_src);
    st_next.cpu_clk = tap(cnt_n, st_reg.cpu_shift, sys_src);

    // register image, unused bits forced to zero
    cpu_v = {6'h00, st_reg.cpu_sel, 1'b0};
    per_v = {6'h00, st_reg.per_sel};
    slow_v = {7'h00, st_reg.slow_halt};
    hit_c = (addr == CPU_DIV_ADDR);
    hit_p = (addr == PERIPH_DIV_ADDR);
    hit_s = (addr == SLOW_OSC_MODE_ADDR);
    wr_any = wr_en | bit_wr_en;

    // byte write takes wdata, bit write patches one bit of the image
    if (wr_en) begin
      mask_b = 8'hff;
    end else if (bit_wr_en) begin
      mask_b = 8'h01 << bit_sel;
    end
    if (wr_any && hit_c) begin
      cpu_v = (cpu_v & ~mask_b) | ((wr_en ? wdata : {8{bit_val}}) & mask_b);
      cpu_v = cpu_v & CPU_DIV_MASK;
      st_next.cpu_sel = cpu_v[CPU_DIVIDE_SELECT_BIT];
    end
    if (wr_any && hit_p) begin
      per_v = (per_v & ~mask_b) | ((wr_en ? wdata : {8{bit_val}}) & mask_b);
      per_v = per_v & PERIPH_DIV_MASK;
      st_next.per_sel = {per_v[PERIPH_DIVIDE_HIGH_BIT],
                         per_v[PERIPH_DIVIDE_LOW_BIT]};
    end
    // a locked option makes the mode register inert
    if (wr_any && hit_s && st_reg.opt_stop) begin
      slow_v = (slow_v & ~mask_b) |
               ((wr_en ? wdata : {8{bit_val}}) & mask_b);
      slow_v = slow_v & SLOW_OSC_MODE_MASK;
      st_next.slow_halt = slow_v[SLOW_OSC_HALT_BIT];
    end

    // legal combinations become the pending ratio; illegal ones leave
    // the running selection untouched
    code = cpu_code({st_next.per_sel, st_next.cpu_sel});
    if (code[3]) begin
      st_next.pend_cpu_shift = code[2:0];
      case (st_next.per_sel)
        PER_SEL_DIV2: st_next.pend_per_shift = 2'h1;
        PER_SEL_DIV4: st_next.pend_per_shift = 2'h2;
        default: st_next.pend_per_shift = 2'h0;
      endcase
    end

    // registered read data, unmapped addresses read zero
    st_next.rd_hit = rd_en & (hit_c | hit_p | hit_s);
    st_next.rdata = 8'h00;
    if (rd_en) begin
      if (hit_c) begin
        st_next.rdata = {6'h00, st_reg.cpu_sel, 1'b0};
      end else if (hit_p) begin
        st_next.rdata = {6'h00, st_reg.per_sel};
      end else if (hit_s) begin
        st_next.rdata = {7'h00, st_reg.slow_halt};
      end
    end

    // options are caught while reset is held, so they are constant after
    if (reset) begin
      st_next = '0;
      st_next.opt_ext = opt_ext_clock;
      st_next.opt_stop = opt_slow_stoppable;
      st_next.cpu_sel = CPU_DIV_RST[CPU_DIVIDE_SELECT_BIT];
      st_next.per_sel = PERIPH_DIV_RST[1:0];
      st_next.slow_halt = SLOW_OSC_MODE_RST[SLOW_OSC_HALT_BIT];
      // reset code {1,0,1} selects system clock / 16
      code = cpu_code({PERIPH_DIV_RST[1:0],
                       CPU_DIV_RST[CPU_DIVIDE_SELECT_BIT]});
      st_next.cpu_shift = code[2:0];
      st_next.pend_cpu_shift = st_next.cpu_shift;
      st_next.per_shift = 2'h2;
      st_next.pend_per_shift = 2'h2;
    end
  end

  // single state register; ce low holds everything, reset still wins
  always_ff @(posedge mclk) begin
    if (ce || reset) begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign rd_hit = st_reg.rd_hit;
  assign sys_clk_external = st_reg.opt_ext;
  assign external_pin_free = ~st_reg.opt_ext;
  assign periph_clk = st_reg.periph_clk;
  assign periph_tick = st_reg.periph_tick;
  assign cpu_clk = st_reg.cpu_clk;
  assign cpu_tick = st_reg.cpu_tick;
  // two cpu clocks expressed in system clocks
  assign min_instr_sysclks =
    6'(MIN_INSTR_CPU_CLOCKS) << st_reg.cpu_shift;
  // runs from reset release; halt honoured only when option allows
  assign slow_osc_run =
    ~(st_reg.opt_stop & st_reg.slow_halt);
  assign wdt_slow_forced = ~st_reg.opt_stop;
  // watchdog loses the slow clock in standby only when stoppable
  assign wdt_slow_clk_en = slow_osc_run & (~standby | ~st_reg.opt_stop);
  // interval timer keeps counting through standby
  assign timer_slow_clk_en = slow_osc_run;
endmodule : clock_prescaler_control

// ### testbench/ext_clock_source.sv
// ext_clock_source: free-running oscillator that feeds the external pin.
// assumes the bench keeps the half period inside the 1 to 10 mhz band.
`timescale 1ns/1ps
module ext_clock_source (
  input wire logic run, // oscillator powered
  input wire logic [9:0] half_ns, // half period in ns
  output logic clk_out // clock pin level
);
  // free runs while powered; held low when off so no stale edge leaks
  initial begin
    clk_out = 1'b0;
    forever begin
      #((half_ns > 10'h000) ? half_ns : 10'h032);
      clk_out = run ? ~clk_out : 1'b0;
    end
  end
endmodule : ext_clock_source

// ### testbench/clock_prescaler_control_checker.sv
// checker: port-level properties of the clock prescaler control.
// assumes a single mclk domain with synchronous active high reset.
`timescale 1ns/1ps
module clock_prescaler_control_checker (
  input wire logic mclk, // clock
  input wire logic reset, // sync reset
  input wire logic ce, // clock enable
  input wire logic [15:0] addr, // cpu address
  input wire logic rd_en, // read strobe
  input wire logic standby, // cpu standby
  input wire logic [7:0] rdata, // read data
  input wire logic rd_hit, // read hit
  input wire logic sys_clk_external, // external source chosen
  input wire logic external_pin_free, // pin released
  input wire logic cpu_tick, // cpu edge pulse
  input wire logic [5:0] min_instr_sysclks, // shortest instruction
  input wire logic slow_osc_run, // slow osc enable
  input wire logic wdt_slow_forced, // watchdog pinned to slow clock
  input wire logic wdt_slow_clk_en, // slow clock to watchdog
  input wire logic timer_slow_clk_en // slow clock to timer
);
  import clkgen_pkg::*;
  logic mapped;
  // decode kept apart so both read sequences share it
  assign mapped = addr == CPU_DIV_ADDR || addr == PERIPH_DIV_ADDR ||
                  addr == SLOW_OSC_MODE_ADDR;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_map_rd;
    rd_en && ce && mapped;
  endsequence
  sequence s_unmap_rd;
    rd_en && ce && !mapped;
  endsequence
  chk_read_answer: assert property (s_map_rd |=> rd_hit &&
    rdata[7:2] == 6'h00) else $error("mapped read answer wrong");
  chk_unmapped_read: assert property (s_unmap_rd |=> !rd_hit &&
    rdata == 8'h00) else $error("unmapped read answered");
  chk_pin_release: assert property (
    external_pin_free == !sys_clk_external) else $error("pin release");
  chk_forced_run: assert property (
    wdt_slow_forced |-> slow_osc_run) else $error("slow osc stopped");
  chk_timer_standby: assert property (
    timer_slow_clk_en == slow_osc_run) else $error("timer clock gated");
  chk_wdt_gate: assert property ($stable(standby) |->
    wdt_slow_clk_en == (slow_osc_run && (!standby || wdt_slow_forced)))
    else $error("watchdog clock gating wrong");
  chk_reset_state: assert property ($fell(reset) |-> slow_osc_run &&
    min_instr_sysclks == 6'h20 && !cpu_tick) else $error("reset state");
  chk_instr_pow: assert property ($onehot(min_instr_sysclks) &&
    !min_instr_sysclks[0]) else $error("instruction time not 2^n");
  // ce low freezes the tick register, so only a running edge counts
  chk_tick_single: assert property (cpu_tick && ce |=> !cpu_tick)
    else $error("cpu tick longer than one cycle");
endmodule : clock_prescaler_control_checker

bind clock_prescaler_control clock_prescaler_control_checker chk_i (
  .mclk(mclk), .reset(reset), .ce(ce), .addr(addr), .rd_en(rd_en),
  .standby(standby), .rdata(rdata), .rd_hit(rd_hit),
  .sys_clk_external(sys_clk_external),
  .external_pin_free(external_pin_free), .cpu_tick(cpu_tick),
  .min_instr_sysclks(min_instr_sysclks), .slow_osc_run(slow_osc_run),
  .wdt_slow_forced(wdt_slow_forced), .wdt_slow_clk_en(wdt_slow_clk_en),
  .timer_slow_clk_en(timer_slow_clk_en)
);

// ### testbench/clock_prescaler_control_tb_top.sv
// clock_prescaler_control_tb_top: directed scenarios for the prescaler.
// assumes the checker is bound in and the partner drives the clock pin.
`timescale 1ns/1ps
module clock_prescaler_control_tb_top;
  import clkgen_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, ce = 1'b1, opt_ext = 1'b0;
  logic opt_stop = 1'b0, hs = 1'b0, ext_pin, standby = 1'b0;
  logic wr_en = 1'b0, bit_wr_en = 1'b0, bit_val = 1'b0, rd_en = 1'b0;
  logic ext_run = 1'b0, rd_hit, sys_ext, pin_free, ptick, ctick;
  logic slow_run, wdt_forced, wdt_en, tmr_en, pclk, cclk;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [15:0] addr = 16'h0000;
  logic [9:0] ext_half = 10'h032;
  logic [5:0] min_instr;
  int num_errors = 0, checks = 0;
  clock_prescaler_control dut (
    .mclk(mclk), .reset(reset), .ce(ce), .opt_ext_clock(opt_ext),
    .opt_slow_stoppable(opt_stop), .hs_osc_clk(hs),
    .external_clock_pin(ext_pin), .standby(standby), .addr(addr),
    .wr_en(wr_en), .bit_wr_en(bit_wr_en), .bit_sel(bit_sel),
    .bit_val(bit_val), .wdata(wdata), .rd_en(rd_en), .rdata(rdata),
    .rd_hit(rd_hit), .sys_clk_external(sys_ext),
    .external_pin_free(pin_free), .periph_clk(pclk), .periph_tick(ptick),
    .cpu_clk(cclk), .cpu_tick(ctick), .min_instr_sysclks(min_instr),
    .slow_osc_run(slow_run), .wdt_slow_forced(wdt_forced),
    .wdt_slow_clk_en(wdt_en), .timer_slow_clk_en(tmr_en)
  );
  ext_clock_source src (.run(ext_run), .half_ns(ext_half), .clk_out(ext_pin));
  // 100 mhz clock; internal oscillator at a quarter of it
  initial begin
    forever #5 mclk = ~mclk;
  end
  always begin
    repeat (2) @(negedge mclk);
    hs = ~hs;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // k: 0 byte write, 1 bit write (sel d[2:0], value d[7]), 2 read
  task automatic acc(input int k, input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    bit_sel = d[2:0];
    bit_val = d[7];
    wr_en = (k == 0);
    bit_wr_en = (k == 1);
    rd_en = (k == 2);
    @(negedge mclk);
    {wr_en, bit_wr_en, rd_en} = 3'h0;
  endtask : acc
  // cycles between two ticks; bounded so a dead divider cannot hang
  task automatic gap(input logic per, output int n);
    n = 0;
    for (int i = 0; i < 4000 && !(per ? ptick : ctick); i++) @(negedge mclk);
    do begin
      @(negedge mclk);
      n++;
    end while (!(per ? ptick : ctick) && n < 4000);
  endtask : gap
  task automatic do_reset(input logic ext, input logic stop);
    @(negedge mclk);
    opt_ext = ext;
    opt_stop = stop;
    reset = 1'b1;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
  endtask : do_reset
  task automatic t_reset_vals();
    do_reset(1'b0, 1'b1);
    acc(2, CPU_DIV_ADDR, 8'h00);
    chk(rdata, 8'h02);
    acc(2, PERIPH_DIV_ADDR, 8'h00);
    chk(rdata, 8'h02);
    acc(2, SLOW_OSC_MODE_ADDR, 8'h00);
    chk(rdata, 8'h00);
    acc(2, 16'hff59, 8'h00);
    chk({rd_hit, rdata}, 9'h000);
    chk({slow_run, pin_free, sys_ext, min_instr}, 9'h1a0);
    // a write while ce is low must not land
    ce = 1'b0;
    acc(0, CPU_DIV_ADDR, 8'h00);
    ce = 1'b1;
    acc(2, CPU_DIV_ADDR, 8'h00);
    chk(rdata, 8'h02);
  endtask : t_reset_vals
  task automatic t_ratios();
    logic [2:0] code [6] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h3, 3'h5};
    int cdiv [6] = '{1, 2, 4, 4, 8, 16};
    int n;
    for (int k = 0; k < 6; k++) begin
      acc(0, PERIPH_DIV_ADDR, {6'h00, code[k][2:1]});
      acc(0, CPU_DIV_ADDR, {6'h00, code[k][0], 1'b0});
      repeat (100) @(negedge mclk);
      gap(1'b0, n);
      chk(n, 4 * cdiv[k]);
      chk(cclk, 1'b1);
      gap(1'b1, n);
      chk(n, 4 << code[k][2:1]);
      chk(pclk, 1'b1);
      chk(min_instr, 2 * cdiv[k]);
    end
    // prohibited code is stored but must leave the /16 selection alone
    acc(0, PERIPH_DIV_ADDR, 8'h03);
    acc(2, PERIPH_DIV_ADDR, 8'h00);
    chk(rdata, 8'h03);
    repeat (100) @(negedge mclk);
    gap(1'b0, n);
    chk(n, 64);
    acc(0, PERIPH_DIV_ADDR, 8'h02);
    acc(1, CPU_DIV_ADDR, 8'h01);
    acc(1, CPU_DIV_ADDR, 8'h87);
    acc(2, CPU_DIV_ADDR, 8'h00);
    chk(rdata, 8'h00);
  endtask : t_ratios
  task automatic t_slow();
    do_reset(1'b0, 1'b1);
    chk(wdt_forced, 1'b0);
    acc(0, SLOW_OSC_MODE_ADDR, 8'hff);
    acc(2, SLOW_OSC_MODE_ADDR, 8'h00);
    chk({rdata, slow_run, tmr_en}, 10'h004);
    acc(1, SLOW_OSC_MODE_ADDR, 8'h00);
    standby = 1'b1;
    @(negedge mclk);
    chk({slow_run, tmr_en, wdt_en}, 3'h6);
    standby = 1'b0;
    do_reset(1'b0, 1'b0);
    acc(0, SLOW_OSC_MODE_ADDR, 8'h01);
    acc(2, SLOW_OSC_MODE_ADDR, 8'h00);
    chk(rdata, 8'h00);
    chk({slow_run, wdt_forced, wdt_en}, 3'h7);
  endtask : t_slow
  task automatic t_ext();
    int n;
    ext_run = 1'b1;
    do_reset(1'b1, 1'b0);
    chk({sys_ext, pin_free}, 2'h2);
    repeat (200) @(negedge mclk);
    gap(1'b1, n);
    chk(n, 40);
    ext_half = 10'h1f4;
    repeat (2000) @(negedge mclk);
    gap(1'b1, n);
    chk(n, 400);
    ext_run = 1'b0;
  endtask : t_ext
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // main sequence, then a watchdog well past the expected run length
  initial begin
    t_reset_vals();
    t_ratios();
    t_slow();
    t_ext();
    tally_and_finish();
  end
  initial begin
    #200us;
    num_errors++;
    tally_and_finish();
  end
endmodule : clock_prescaler_control_tb_top
